// File: sdrfr_pkg.sv
/*
 * Shared constants, types and register map of the radio uplink packet framer.
 * Assumes one pclk domain; all sample sources sit on that same clock.
 */
package sdrfr_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DST_PORT = 8'h04;
	localparam logic [7:0] ADDR_HP_PORT = 8'h08;
	localparam logic [7:0] ADDR_MIC_PORT = 8'h0c;
	localparam logic [7:0] ADDR_WB_PORT = 8'h10;
	localparam logic [7:0] ADDR_DDC_PORT = 8'h14;
	localparam logic [7:0] ADDR_WB_CFG = 8'h18;
	localparam logic [7:0] ADDR_DDC_CFG = 8'h1c;
	localparam logic [7:0] ADDR_STATE = 8'h20;
	localparam logic [7:0] ADDR_TS_LO = 8'h24;
	localparam logic [7:0] ADDR_TS_HI = 8'h28;

	localparam int CTRL_STOP_BIT = 0;
	localparam int CTRL_HP_SEND_BIT = 1;
	localparam int CTRL_MIC_EN_BIT = 2;
	localparam int CTRL_DDC_EN_BIT = 3;
	localparam int CTRL_WB_EN_LSB = 8;

	localparam logic [15:0] HP_PORT_DEF = 16'h0401;
	localparam logic [15:0] MIC_PORT_DEF = 16'h0402;
	localparam logic [15:0] WB_PORT_DEF = 16'h0403;
	localparam logic [15:0] DDC_PORT_DEF = 16'h040b;

	localparam logic [15:0] MIC_SAMPLES = 16'h0040;
	localparam logic [15:0] WB_SPP_RST = 16'h0200;
	localparam logic [15:0] WB_PPB_RST = 16'h0001;
	localparam logic [5:0] DDC_BPS_RST = 6'h18;
	localparam logic [15:0] DDC_SPF_RST = 16'h00ee;
	localparam logic [2:0] DDC_NB_FALLBACK = 3'h3;

	localparam logic [5:0] HP_BYTES = 6'h3c;
	localparam logic [5:0] SEQ_BYTES = 6'h04;
	localparam logic [5:0] DDC_HDR_BYTES = 6'h10;
	localparam logic [5:0] SAMP16_BYTES = 6'h02;
	localparam int SH_W = 480;

	localparam int SEQ_HP = 0;
	localparam int SEQ_MIC = 1;
	localparam int SEQ_DDC = 2;
	localparam int SEQ_WB0 = 3;

	typedef enum logic [1:0] {
		SDRFR_IDLE = 2'b00,
		SDRFR_SEND = 2'b01,
		SDRFR_FETCH = 2'b11
	} sdrfr_state_e;

	typedef enum logic [1:0] {
		SDRFR_KIND_HP = 2'b00,
		SDRFR_KIND_MIC = 2'b01,
		SDRFR_KIND_WB = 2'b10,
		SDRFR_KIND_DDC = 2'b11
	} sdrfr_kind_e;

	typedef struct packed {
		logic [7:0] data;
		logic first;
		logic last;
		sdrfr_kind_e kind;
		logic [15:0] src_port;
		logic [15:0] dst_port;
	} sdrfr_byte_s;

	typedef struct packed {
		logic [7:0] misc;
		logic [7:0] overload;
		logic [15:0] exc_fwd;
		logic [15:0] pa_fwd;
		logic [15:0] pa_rev;
		logic [15:0] supply;
		logic [15:0] user_adc3;
		logic [15:0] user_adc2;
		logic [15:0] user_adc1;
		logic [15:0] user_adc0;
	} sdrfr_status_s;
endpackage : sdrfr_pkg

// File: sdrfr_framer.sv
/*
 * Uplink packet framer: builds status, microphone, wideband and DDC payloads
 * as a byte stream with APB control registers.
 * Assumes sample sources, status readings and adc_tick share pclk; user pins
 * and the pulse-per-second reference are asynchronous.
 */
// Design decisions made here: the register addresses and the APB slave port.
// How it works
// - Status byte 5 bit n copies overload flag of converter n.
// - Exciter forward power goes in status bytes 6-7, high byte first.
// - Amplifier forward power goes in status bytes 14-15, high byte first.
// - Amplifier reverse power goes in status bytes 22-23, high byte first.
// - Supply voltage word goes in status bytes 49-50.
// - Four user analogue words fill status bytes 51 to 58.
// - Last status byte: user pins four, five, six, eight, two; top bits zero.
// - Microphone packet carries 64 samples after the sequence number.
// - Microphone samples are 2-byte signed, oldest first.
// - Microphone source port is the configured one, 1026 when zero.
// - Every stream packet goes to the host's discovery source port.
// - Each port has its own 32-bit sequence counter that wraps.
// - Sequence counters clear at reset and on a stop command.
// - Wideband packets go out only while that converter is enabled.
// - Wideband port is configured or 1027, plus one per further source.
// - Wideband packets hold 2-byte raw samples, 512 per packet by default.
// - Wideband sequence restarts at zero after each configured block.
// - 64-bit time stamp counts samples, clears on reference rising edge.
// - DDC header states the sample width in two bytes.
// - DDC header states the count of following sample sets.
// - DDC sample width may be 8, 16, 24 or 32 bits.
// - Each DDC pair is in-phase then quadrature, pairs in time order.
// - Status source port is the configured one, 1025 when zero.
module sdrfr_framer #(
	parameter int NWB = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hp_send,
	input wire sdrfr_pkg::sdrfr_status_s status,
	input wire logic user_input_pin_four,
	input wire logic user_input_pin_five,
	input wire logic user_input_pin_six,
	input wire logic user_input_pin_eight,
	input wire logic user_input_pin_two,
	input wire logic pulse_per_second_reference,
	input wire logic adc_tick,
	input wire logic mic_valid,
	input wire logic [15:0] mic_sample,
	output logic mic_ready,
	input wire logic [NWB-1:0] wb_valid,
	input wire logic [NWB*16-1:0] wb_sample,
	output logic [NWB-1:0] wb_ready,
	input wire logic ddc_valid,
	input wire logic [31:0] ddc_i,
	input wire logic [31:0] ddc_q,
	output logic ddc_ready,
	output sdrfr_pkg::sdrfr_byte_s tx,
	output logic tx_valid,
	input wire logic tx_ready
);
	import sdrfr_pkg::*;

	localparam int NPORT = SEQ_WB0 + NWB;
	localparam int NSRC = 2 + NWB;

	sdrfr_state_e state_reg;
	sdrfr_kind_e kind_reg;
	logic [SH_W-1:0] sh_reg;
	logic [5:0] cnt_reg;
	logic [15:0] elems_reg;
	logic [5:0] eb_reg;
	logic first_reg;
	logic [NSRC-1:0] src_mask_reg;
	logic [NSRC-1:0] rdy_reg;
	logic [$clog2(NWB+1)-1:0] wb_sel_reg;
	logic [15:0] port_reg;
	logic [31:0] seq_reg [NPORT];
	logic hp_pend_reg;
	logic [63:0] ts_reg;
	logic pps_s1_reg, pps_s2_reg, pps_s3_reg;
	logic [4:0] din_s1_reg, din_s2_reg;
	logic [31:0] ctrl_reg;
	logic [15:0] dst_reg, hp_port_reg, mic_port_reg, wb_port_reg, ddc_port_reg;
	logic [15:0] wb_spp_reg, wb_ppb_reg, ddc_spf_reg;
	logic [5:0] ddc_bps_reg;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg;
	sdrfr_byte_s tx_reg;
	logic tx_valid_reg;
	logic [11:0] pkt_len_reg;

	// APB decode; one wait state so read data comes from a flop
	wire apb_acc = psel && penable && !pready_reg;
	wire wr_fire = psel && penable && pready_reg && pwrite;
	wire hit_ctrl = paddr == ADDR_CTRL;
	wire hit_dst = paddr == ADDR_DST_PORT;
	wire hit_hp = paddr == ADDR_HP_PORT;
	wire hit_mic = paddr == ADDR_MIC_PORT;
	wire hit_wb = paddr == ADDR_WB_PORT;
	wire hit_ddc = paddr == ADDR_DDC_PORT;
	wire hit_wbc = paddr == ADDR_WB_CFG;
	wire hit_ddcc = paddr == ADDR_DDC_CFG;
	wire hit_st = paddr == ADDR_STATE;
	wire hit_tsl = paddr == ADDR_TS_LO;
	wire hit_tsh = paddr == ADDR_TS_HI;
	wire hit_any = hit_ctrl | hit_dst | hit_hp | hit_mic | hit_wb | hit_ddc | hit_wbc |
		hit_ddcc | hit_st | hit_tsl | hit_tsh;
	wire stop_cmd = wr_fire && hit_ctrl && pwdata[CTRL_STOP_BIT];
	wire hp_sw_req = wr_fire && hit_ctrl && pwdata[CTRL_HP_SEND_BIT];
	wire mic_en = ctrl_reg[CTRL_MIC_EN_BIT];
	wire ddc_en = ctrl_reg[CTRL_DDC_EN_BIT];
	wire [NWB-1:0] wb_en = ctrl_reg[CTRL_WB_EN_LSB +: NWB];
	wire [31:0] rd_mux =
		hit_ctrl ? {ctrl_reg[31:2], 2'b00} :
		hit_dst ? {16'h0000, dst_reg} :
		hit_hp ? {16'h0000, hp_port_reg} :
		hit_mic ? {16'h0000, mic_port_reg} :
		hit_wb ? {16'h0000, wb_port_reg} :
		hit_ddc ? {16'h0000, ddc_port_reg} :
		hit_wbc ? {wb_ppb_reg, wb_spp_reg} :
		hit_ddcc ? {ddc_spf_reg, 10'h000, ddc_bps_reg} :
		hit_st ? {27'h0000000, hp_pend_reg, kind_reg, state_reg} :
		hit_tsl ? ts_reg[31:0] :
		hit_tsh ? ts_reg[63:32] : 32'h00000000;

	// Effective ports: zero selects the default
	wire [15:0] hp_src = (hp_port_reg == 16'h0000) ? HP_PORT_DEF : hp_port_reg;
	wire [15:0] mic_src = (mic_port_reg == 16'h0000) ? MIC_PORT_DEF : mic_port_reg;
	wire [15:0] wb_base = (wb_port_reg == 16'h0000) ? WB_PORT_DEF : wb_port_reg;
	wire [15:0] ddc_src = (ddc_port_reg == 16'h0000) ? DDC_PORT_DEF : ddc_port_reg;

	// Odd widths fall back to 24 bits rather than misframe the pair
	wire [2:0] nb_raw = ddc_bps_reg[5:3];
	wire nb_ok = (ddc_bps_reg[2:0] == 3'h0) && (nb_raw != 3'h0) && (nb_raw <= 3'h4);
	wire [2:0] ddc_nb = nb_ok ? nb_raw : DDC_NB_FALLBACK;
	wire [31:0] i_al = ddc_i << {3'h4 - ddc_nb, 3'b000};
	wire [31:0] q_al = ddc_q << {3'h4 - ddc_nb, 3'b000};
	wire [63:0] ddc_pair = {i_al, 32'h00000000} | ({q_al, 32'h00000000} >> {ddc_nb, 3'b000});

	// Status tail, bytes 4 to 59
	wire [7:0] user_bits = {3'b000, din_s2_reg};
	wire [447:0] hp_tail = {status.misc, status.overload,
		status.exc_fwd, 48'h0,
		status.pa_fwd, 48'h0,
		status.pa_rev, 200'h0,
		status.supply,
		status.user_adc3, status.user_adc2, status.user_adc1, status.user_adc0,
		user_bits};

	// Start arbitration: status, then DDC, microphone, wideband
	logic [NWB-1:0] wb_req;
	logic [$clog2(NWB+1)-1:0] wb_pick;
	wire wb_any = |wb_req;
	always_comb begin
		wb_pick = '0;
		for (int k = NWB - 1; k >= 0; k--) begin
			if (wb_req[k]) begin
				wb_pick = k[$clog2(NWB+1)-1:0];
			end
		end
	end
	assign wb_req = wb_en & wb_valid;
	wire idle = state_reg == SDRFR_IDLE;
	wire go_hp = idle && hp_pend_reg;
	wire go_ddc = idle && !hp_pend_reg && ddc_en && ddc_valid;
	wire go_mic = idle && !hp_pend_reg && !(ddc_en && ddc_valid) && mic_en && mic_valid;
	wire go_wb = idle && !hp_pend_reg && !(ddc_en && ddc_valid) && !(mic_en && mic_valid) && wb_any;
	wire start = go_hp | go_ddc | go_mic | go_wb;
	wire [31:0] wb_seq_now = seq_reg[SEQ_WB0 + int'(wb_pick)];

	wire out_free = !tx_valid_reg || tx_ready;
	wire emit = (state_reg == SDRFR_SEND) && out_free;
	wire cur_valid = |(src_mask_reg & {wb_valid, ddc_valid, mic_valid});
	wire take = (state_reg == SDRFR_FETCH) && |(rdy_reg & src_mask_reg) && cur_valid;
	wire [15:0] wb_cur = wb_sample[int'(wb_sel_reg)*16 +: 16];
	wire [63:0] samp_in = (kind_reg == SDRFR_KIND_DDC) ? ddc_pair :
		(kind_reg == SDRFR_KIND_WB) ? {wb_cur, 48'h0} : {mic_sample, 48'h0};
	wire last_byte = (cnt_reg == 6'h01) && (elems_reg == 16'h0000);

	// Registers written over APB
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= 32'h00000000;
			dst_reg <= 16'h0000;
			hp_port_reg <= 16'h0000;
			mic_port_reg <= 16'h0000;
			wb_port_reg <= 16'h0000;
			ddc_port_reg <= 16'h0000;
			wb_spp_reg <= WB_SPP_RST;
			wb_ppb_reg <= WB_PPB_RST;
			ddc_bps_reg <= DDC_BPS_RST;
			ddc_spf_reg <= DDC_SPF_RST;
		end else if (ce && wr_fire) begin
			if (hit_ctrl) ctrl_reg <= pwdata;
			if (hit_dst) dst_reg <= pwdata[15:0];
			if (hit_hp) hp_port_reg <= pwdata[15:0];
			if (hit_mic) mic_port_reg <= pwdata[15:0];
			if (hit_wb) wb_port_reg <= pwdata[15:0];
			if (hit_ddc) ddc_port_reg <= pwdata[15:0];
			if (hit_wbc) begin
				wb_spp_reg <= pwdata[15:0];
				wb_ppb_reg <= pwdata[31:16];
			end
			if (hit_ddcc) begin
				ddc_bps_reg <= pwdata[5:0];
				ddc_spf_reg <= pwdata[31:16];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else if (ce) begin
			pready_reg <= apb_acc;
			pslverr_reg <= apb_acc && !hit_any;
			prdata_reg <= (apb_acc && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// Asynchronous pins: two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pps_s1_reg <= 1'b0;
			pps_s2_reg <= 1'b0;
			pps_s3_reg <= 1'b0;
			din_s1_reg <= 5'h00;
			din_s2_reg <= 5'h00;
		end else if (ce) begin
			pps_s1_reg <= pulse_per_second_reference;
			pps_s2_reg <= pps_s1_reg;
			pps_s3_reg <= pps_s2_reg;
			din_s1_reg <= {user_input_pin_two, user_input_pin_eight, user_input_pin_six,
				user_input_pin_five, user_input_pin_four};
			din_s2_reg <= din_s1_reg;
		end
	end

	wire pps_rise = pps_s2_reg && !pps_s3_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_reg <= 64'h0;
		end else if (ce) begin
			if (pps_rise) ts_reg <= 64'h0;
			else if (adc_tick) ts_reg <= ts_reg + 64'h1;
		end
	end

	// Set wins over the clear taken at packet start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hp_pend_reg <= 1'b0;
		else if (ce) hp_pend_reg <= hp_send || hp_sw_req || (hp_pend_reg && !go_hp);
	end

	// One counter per port; wideband ones restart per block and when disabled
	genvar g;
	generate
		for (g = 0; g < NPORT; g++) begin : g_seq
			wire hit = (g == SEQ_HP) ? go_hp : (g == SEQ_MIC) ? go_mic :
				(g == SEQ_DDC) ? go_ddc : (go_wb && int'(wb_pick) == g - SEQ_WB0);
			wire [31:0] nxt = seq_reg[g] + 32'h1;
			wire blk_end = (g >= SEQ_WB0) && (wb_ppb_reg != 16'h0000) &&
				(nxt >= {16'h0000, wb_ppb_reg});
			wire dis = (g >= SEQ_WB0) && !wb_en[(g >= SEQ_WB0) ? g - SEQ_WB0 : 0];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) seq_reg[g] <= 32'h0;
				else if (ce) begin
					if (stop_cmd || dis) seq_reg[g] <= 32'h0;
					else if (hit) seq_reg[g] <= blk_end ? 32'h0 : nxt;
				end
			end
		end
	endgenerate

	// Packet sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= SDRFR_IDLE;
			kind_reg <= SDRFR_KIND_HP;
			sh_reg <= '0;
			cnt_reg <= 6'h00;
			elems_reg <= 16'h0000;
			eb_reg <= 6'h00;
			first_reg <= 1'b0;
			src_mask_reg <= '0;
			rdy_reg <= '0;
			wb_sel_reg <= '0;
			port_reg <= 16'h0000;
		end else if (ce) begin
			case (state_reg)
				SDRFR_IDLE: begin
					first_reg <= 1'b1;
					if (go_hp) begin
						kind_reg <= SDRFR_KIND_HP;
						sh_reg <= {seq_reg[SEQ_HP], hp_tail};
						cnt_reg <= HP_BYTES;
						elems_reg <= 16'h0000;
						src_mask_reg <= '0;
						port_reg <= hp_src;
					end else if (go_ddc) begin
						kind_reg <= SDRFR_KIND_DDC;
						sh_reg <= {seq_reg[SEQ_DDC], ts_reg, 10'h000, ddc_nb, 3'b000,
							ddc_spf_reg, 352'h0};
						cnt_reg <= DDC_HDR_BYTES;
						elems_reg <= ddc_spf_reg;
						eb_reg <= {2'b00, ddc_nb, 1'b0};
						src_mask_reg <= NSRC'(2);
						port_reg <= ddc_src;
					end else if (go_mic) begin
						kind_reg <= SDRFR_KIND_MIC;
						sh_reg <= {seq_reg[SEQ_MIC], 448'h0};
						cnt_reg <= SEQ_BYTES;
						elems_reg <= MIC_SAMPLES;
						eb_reg <= SAMP16_BYTES;
						src_mask_reg <= NSRC'(1);
						port_reg <= mic_src;
					end else if (go_wb) begin
						kind_reg <= SDRFR_KIND_WB;
						sh_reg <= {wb_seq_now, 448'h0};
						cnt_reg <= SEQ_BYTES;
						elems_reg <= wb_spp_reg;
						eb_reg <= SAMP16_BYTES;
						src_mask_reg <= NSRC'(4) << wb_pick;
						wb_sel_reg <= wb_pick;
						port_reg <= wb_base + 16'(wb_pick);
					end
					if (start) state_reg <= SDRFR_SEND;
				end
				SDRFR_SEND: begin
					if (emit) begin
						first_reg <= 1'b0;
						sh_reg <= sh_reg << 8;
						cnt_reg <= cnt_reg - 6'h01;
						if (cnt_reg == 6'h01) begin
							state_reg <= (elems_reg == 16'h0000) ? SDRFR_IDLE : SDRFR_FETCH;
							rdy_reg <= (elems_reg == 16'h0000) ? '0 : src_mask_reg;
						end
					end
				end
				SDRFR_FETCH: begin
					if (take) begin
						sh_reg <= {samp_in, 416'h0};
						cnt_reg <= eb_reg;
						elems_reg <= elems_reg - 16'h0001;
						rdy_reg <= '0;
						state_reg <= SDRFR_SEND;
					end
				end
				default: state_reg <= SDRFR_IDLE;
			endcase
		end
	end

	// Output byte register; held until the sink takes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_reg <= '0;
			tx_valid_reg <= 1'b0;
			pkt_len_reg <= 12'h000;
		end else if (ce) begin
			if (emit) begin
				tx_valid_reg <= 1'b1;
				tx_reg.data <= sh_reg[SH_W-1 -: 8];
				tx_reg.first <= first_reg;
				tx_reg.last <= last_byte;
				tx_reg.kind <= kind_reg;
				tx_reg.src_port <= port_reg;
				tx_reg.dst_port <= dst_reg;
				pkt_len_reg <= first_reg ? 12'h001 : pkt_len_reg + 12'h001;
			end else if (tx_ready) begin
				tx_valid_reg <= 1'b0;
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign tx = tx_reg;
	assign tx_valid = tx_valid_reg;
	assign mic_ready = rdy_reg[0];
	assign ddc_ready = rdy_reg[1];
	assign wb_ready = rdy_reg[NSRC-1:2];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_stall;
		tx_valid && !tx_ready;
	endsequence
	property p_hold;
		s_stall |=> $stable(tx.data) && tx_valid;
	endproperty
	a_hold: assert property (p_hold) else $error("tx byte changed while stalled");

	property p_mic_len;
		tx_valid && tx.last && tx.kind == SDRFR_KIND_MIC |-> pkt_len_reg == 12'd132;
	endproperty
	a_mic_len: assert property (p_mic_len) else $error("mic packet not 132 bytes");

	property p_hp_len;
		tx_valid && tx.last && tx.kind == SDRFR_KIND_HP |-> pkt_len_reg == 12'd60;
	endproperty
	a_hp_len: assert property (p_hp_len) else $error("status packet not 60 bytes");

	property p_mic_port;
		tx_valid && tx.kind == SDRFR_KIND_MIC |-> tx.src_port == mic_src;
	endproperty
	a_mic_port: assert property (p_mic_port) else $error("wrong mic source port");

	property p_hp_port;
		tx_valid && tx.kind == SDRFR_KIND_HP |-> tx.src_port == hp_src;
	endproperty
	a_hp_port: assert property (p_hp_port) else $error("wrong status source port");

	property p_dst;
		ce && emit |=> tx.dst_port == $past(dst_reg);
	endproperty
	a_dst: assert property (p_dst) else $error("wrong destination port");

	property p_stop;
		ce && stop_cmd |=> seq_reg[SEQ_MIC] == 32'h0 && seq_reg[SEQ_HP] == 32'h0;
	endproperty
	a_stop: assert property (p_stop) else $error("stop left a counter nonzero");

	property p_seq_inc;
		ce && go_mic && !stop_cmd |=> seq_reg[SEQ_MIC] == $past(seq_reg[SEQ_MIC]) + 32'h1;
	endproperty
	a_seq_inc: assert property (p_seq_inc) else $error("mic sequence did not step");

	sequence s_pps_edge;
		ce && pps_rise;
	endsequence
	property p_ts_clr;
		s_pps_edge |=> ts_reg == 64'h0;
	endproperty
	a_ts_clr: assert property (p_ts_clr) else $error("time stamp not cleared");

	property p_wb_gate;
		|wb_ready |-> state_reg == SDRFR_FETCH && kind_reg == SDRFR_KIND_WB;
	endproperty
	a_wb_gate: assert property (p_wb_gate) else $error("wideband fetch outside packet");
endmodule : sdrfr_framer

// File: sdrfr_host_model.sv
/*
 * Host sink model for the uplink framer byte stream: collects each packet.
 * Assumes tx/tx_valid on pclk; slow makes it accept one byte in four.
 */
module sdrfr_host_model (
	input wire logic pclk,
	input wire logic slow,
	input wire sdrfr_pkg::sdrfr_byte_s tx,
	input wire logic tx_valid,
	output logic tx_ready
);
	import sdrfr_pkg::*;
	logic [7:0] pkt [0:1499];
	logic [31:0] seq_log [0:63];
	logic [15:0] src_log [0:63];
	logic [15:0] last_dst = 16'h0000;
	logic [1:0] phase = 2'h0;
	logic [1:0] last_kind = 2'h0;
	int n = 0;
	int done = 0;
	initial tx_ready = 1'b1;
	always @(posedge pclk) begin
		phase <= phase + 2'h1;
		// Stalls like a busy host stack, never drops a byte
		tx_ready <= !slow || phase == 2'h3;
		if (tx_valid && tx_ready) begin
			if (tx.first) n = 0;
			pkt[n] = tx.data;
			n = n + 1;
			if (tx.last) begin
				seq_log[done] = {pkt[0], pkt[1], pkt[2], pkt[3]};
				src_log[done] = tx.src_port;
				last_dst = tx.dst_port;
				last_kind = tx.kind;
				done = done + 1;
			end
		end
	end
endmodule : sdrfr_host_model

// File: test_sdrfr_framer.sv
/*
 * Self-checking bench of the uplink framer: APB tasks, sample sources, host.
 * Assumes the package and host model are compiled first.
 */
module test_sdrfr_framer;
	timeunit 1ns;
	timeprecision 1ns;
	import sdrfr_pkg::*;
	localparam logic [31:0] DI = 32'h44332211;
	localparam logic [31:0] DQ = 32'h88776655;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, mic_ready, ddc_ready, tx_valid, tx_ready, e;
	logic hp_send = 1'b0, pps = 1'b0, adc_tick = 1'b0, slow = 1'b0;
	logic mic_valid = 1'b0, ddc_valid = 1'b0, wb1_n = 1'b0;
	logic [4:0] pins = 5'h0d;
	logic [1:0] wb_valid = 2'h0, wb_ready;
	logic [15:0] mic_idx = 16'h0000, wb_idx = 16'h0000, mic_sample;
	logic [31:0] wb_sample;
	sdrfr_status_s status = '{8'h00, 8'ha5, 16'h1122, 16'h3344, 16'h5566, 16'h7788,
		16'h99aa, 16'hbbcc, 16'hddee, 16'hff01};
	sdrfr_byte_s tx;
	int mismatches = 0;
	int total_checks = 0;
	always #50 pclk = ~pclk;
	assign mic_sample = 16'hfff0 + mic_idx;
	assign wb_sample = {16'h5a5a, 16'h7000 + wb_idx};
	sdrfr_framer DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .hp_send(hp_send),
		.status(status), .user_input_pin_four(pins[0]), .user_input_pin_five(pins[1]),
		.user_input_pin_six(pins[2]), .user_input_pin_eight(pins[3]),
		.user_input_pin_two(pins[4]), .pulse_per_second_reference(pps),
		.adc_tick(adc_tick), .mic_valid(mic_valid), .mic_sample(mic_sample),
		.mic_ready(mic_ready), .wb_valid(wb_valid), .wb_sample(wb_sample),
		.wb_ready(wb_ready), .ddc_valid(ddc_valid), .ddc_i(DI), .ddc_q(DQ),
		.ddc_ready(ddc_ready), .tx(tx), .tx_valid(tx_valid), .tx_ready(tx_ready));
	sdrfr_host_model host (.pclk(pclk), .slow(slow), .tx(tx), .tx_valid(tx_valid),
		.tx_ready(tx_ready));
	// Sources hold valid until taken, then stop after a fixed sample count
	always @(posedge pclk) begin
		if (mic_valid && mic_ready) begin
			mic_idx <= mic_idx + 16'h0001;
			if (mic_idx == 16'h003f) mic_valid <= 1'b0;
		end
		if (wb_valid[0] && wb_ready[0]) begin
			wb_idx <= wb_idx + 16'h0001;
			if (wb_idx == 16'h0005) wb_valid[0] <= 1'b0;
		end
		if (wb_valid[1] && wb_ready[1]) begin
			wb1_n <= 1'b1;
			if (wb1_n) wb_valid[1] <= 1'b0;
		end
		if (ddc_valid && ddc_ready) ddc_valid <= 1'b0;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Waits on pready, never on a fixed latency
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd_data, output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_data = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0, r, e);
		chk(what, exp, r);
	endtask : rd
	task automatic wait_pkt(input int want);
		while (host.done < want) begin
			@(negedge pclk);
		end
		@(posedge pclk);
		chk("packet count", want, host.done);
	endtask : wait_pkt
	task automatic tick(input int cnt);
		for (int k = 0; k < cnt; k++) begin
			adc_tick <= 1'b1;
			@(posedge pclk);
			adc_tick <= 1'b0;
			@(posedge pclk);
		end
	endtask : tick
	function automatic logic [31:0] w32(input int i);
		return {host.pkt[i], host.pkt[i + 1], host.pkt[i + 2], host.pkt[i + 3]};
	endfunction : w32
	function automatic logic [31:0] w16(input int i);
		return {16'h0000, host.pkt[i], host.pkt[i + 1]};
	endfunction : w16
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (60000) @(posedge pclk);
		mismatches++;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ADDR_WB_CFG, 32'h00010200, "wb cfg");
		rd(ADDR_DDC_CFG, 32'h00ee0018, "ddc cfg");
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		wr(ADDR_DST_PORT, 32'h1234);
		slow <= 1'b1;
		hp_send <= 1'b1;
		@(posedge pclk);
		hp_send <= 1'b0;
		wait_pkt(1);
		chk("hp len", 60, host.n);
		chk("hp seq", 32'h0, w32(0));
		chk("overload", 32'ha5, host.pkt[5]);
		chk("exc fwd", 32'h1122, w16(6));
		chk("pa fwd", 32'h3344, w16(14));
		chk("pa rev", 32'h5566, w16(22));
		chk("supply", 32'h7788, w16(49));
		chk("user adc hi", 32'h99aabbcc, w32(51));
		chk("user adc lo", 32'hddeeff01, w32(55));
		chk("pins", 32'h0d, host.pkt[59]);
		chk("hp src", 32'h0401, host.src_log[0]);
		status.overload <= 8'h5a;
		pins <= 5'h12;
		wr(ADDR_HP_PORT, 32'h2000);
		wr(ADDR_CTRL, 32'h2);
		wait_pkt(2);
		chk("hp seq next", 32'h1, w32(0));
		chk("hp src set", 32'h2000, host.src_log[1]);
		chk("overload b", 32'h5a, host.pkt[5]);
		chk("pins b", 32'h12, host.pkt[59]);
		wr(ADDR_CTRL, 32'h1);
		rd(ADDR_CTRL, 32'h0, "ctrl stop reads 0");
		wr(ADDR_CTRL, 32'h2);
		wait_pkt(3);
		chk("seq after stop", 32'h0, w32(0));
		slow <= 1'b0;
		wr(ADDR_CTRL, 32'h4);
		mic_valid <= 1'b1;
		wait_pkt(4);
		chk("mic len", 132, host.n);
		chk("mic src", 32'h0402, host.src_log[3]);
		chk("mic dst", 32'h1234, host.last_dst);
		chk("mic kind", 32'h1, host.last_kind);
		for (int i = 0; i < 64; i++) chk("mic sample", 32'(16'(16'hfff0 + i)), w16(4 + 2 * i));
		wr(ADDR_WB_CFG, 32'h00020002);
		wb_valid[1] <= 1'b1;
		wr(ADDR_CTRL, 32'h100);
		wb_valid[0] <= 1'b1;
		wait_pkt(7);
		repeat (50) @(posedge pclk);
		chk("wb count", 7, host.done);
		chk("wb seq a", 32'h0, host.seq_log[4]);
		chk("wb seq b", 32'h1, host.seq_log[5]);
		chk("wb seq c", 32'h0, host.seq_log[6]);
		chk("wb src", 32'h0403, host.src_log[6]);
		chk("wb len", 8, host.n);
		chk("wb kind", 32'h2, host.last_kind);
		chk("wb sample", 32'h7005, w16(6));
		wr(ADDR_CTRL, 32'h200);
		wait_pkt(8);
		chk("wb1 src", 32'h0404, host.src_log[7]);
		tick(3);
		pps <= 1'b1;
		repeat (6) @(posedge pclk);
		tick(5);
		rd(ADDR_TS_LO, 32'h5, "ts lo");
		wr(ADDR_CTRL, 32'h8);
		for (int w = 1; w <= 4; w++) begin
			wr(ADDR_DDC_CFG, {16'h0001, 10'h000, 6'(8 * w)});
			ddc_valid <= 1'b1;
			wait_pkt(8 + w);
			chk("ddc len", 16 + 2 * w, host.n);
			chk("ddc ts hi", 32'h0, w32(4));
			chk("ddc ts lo", 32'h5, w32(8));
			chk("ddc width", 8 * w, w16(12));
			chk("ddc count", 32'h1, w16(14));
			chk("ddc i", {24'h0, DI[8 * w - 1 -: 8]}, host.pkt[16]);
			chk("ddc q", {24'h0, DQ[8 * w - 1 -: 8]}, host.pkt[16 + w]);
			chk("ddc kind", 32'h3, host.last_kind);
		end
		// Second reset mid-run: counters and ports must come back to defaults
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		hp_send <= 1'b1;
		@(posedge pclk);
		hp_send <= 1'b0;
		wait_pkt(13);
		chk("hp seq reset", 32'h0, w32(0));
		chk("hp src reset", 32'h0401, host.src_log[12]);
		chk("dst reset", 32'h0, host.last_dst);
		give_verdict;
	end
endmodule : test_sdrfr_framer
